// >>> inc/bridge_window_pkg.sv
// How it works
// - Offset 28h holds a 32-bit read/write upper start address of the prefetchable window, zero at reset.
// - Offset 2Ch holds a 32-bit read/write upper end address of the prefetchable window, zero at reset.
// - Offset 30h holds a 16-bit read/write I/O start extension, zero at reset, with zeros below.
// - Offset 32h holds a 16-bit read/write I/O end extension, zero at reset, with ones below.
// - Offset 34h always reads 50h and ignores writes.
// - Offset 3Ch is an 8-bit scratch register that resets to FFh and steers nothing.
// - Offset 3Dh always reads 00h because the bridge raises no interrupts itself.
// - Interrupt requests from the secondary side are passed on to the primary side.
// - The window start is the upper start register joined to the lower start field and 20 zeros.
// - The window end is the upper end register joined to the lower end field and 20 ones.
package bridge_window_pkg;

    // ------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_PF_START_HI = 8'h28;
    localparam logic [7:0]  OFS_PF_END_HI   = 8'h2c;
    localparam logic [7:0]  OFS_IO_START_HI = 8'h30;
    localparam logic [7:0]  OFS_IO_END_HI   = 8'h32;
    localparam logic [7:0]  OFS_CAP_PTR     = 8'h34;
    localparam logic [7:0]  OFS_INT_SCRATCH = 8'h3c;
    localparam logic [7:0]  OFS_INT_PIN     = 8'h3d;
    localparam logic [31:0] RST_PF_HI       = 32'h0000_0000;
    localparam logic [15:0] RST_IO_HI       = 16'h0000;
    localparam logic [7:0]  CAP_PTR_VALUE   = 8'h50;
    localparam logic [7:0]  RST_INT_SCRATCH = 8'hff;
    localparam logic [7:0]  INT_PIN_VALUE   = 8'h00;

    // ------------------------------------------------------------
    // Window assembly fill patterns
    // ------------------------------------------------------------
    localparam logic [19:0] LOW_FILL_ZERO   = 20'h00000;
    localparam logic [19:0] LOW_FILL_ONES   = 20'hfffff;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        req;
        logic        we;
        logic [5:0]  index;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic        valid;
        logic        is_io;
        logic [63:0] addr;
    } fwd_req_t;

    // Dword index of a byte offset
    function automatic logic [5:0] cfg_index(input logic [7:0] ofs);
        return ofs[7:2];
    endfunction

    // Byte-lane merge of a configuration write
    function automatic logic [31:0] merge_be(input logic [31:0] old,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

// >>> src/bridge_window_upper_cfg_regs.sv
`timescale 1ns/1ps
module bridge_window_upper_cfg_regs
    import bridge_window_pkg::*;
#(
    parameter int INTX_W = 4
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Configuration access
    input  wire cfg_req_t          cfg_in,
    output logic                   cfg_ack,
    output logic [31:0]            cfg_rdata,
    // Lower window fields, address bits 31:20
    input  wire logic [11:0]       pf_start_low,
    input  wire logic [11:0]       pf_end_low,
    // Forwarding decode
    input  wire fwd_req_t          fwd_in,
    output logic                   fwd_done,
    output logic                   fwd_hit,
    // Interrupt pass-through
    input  wire logic [INTX_W-1:0] intx_secondary,
    output logic [INTX_W-1:0]      intx_primary
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic [31:0] pf_start_hi;
    logic [31:0] pf_end_hi;
    logic [15:0] io_start_hi;
    logic [15:0] io_end_hi;
    logic [7:0]  int_scratch;

    wire         wr_en       = cfg_in.req && cfg_in.we;
    wire         hit_pf_st   = cfg_in.index == cfg_index(OFS_PF_START_HI);
    wire         hit_pf_end  = cfg_in.index == cfg_index(OFS_PF_END_HI);
    wire         hit_io      = cfg_in.index == cfg_index(OFS_IO_START_HI);
    wire         hit_cap     = cfg_in.index == cfg_index(OFS_CAP_PTR);
    wire         hit_int     = cfg_in.index == cfg_index(OFS_INT_SCRATCH);
    wire [31:0]  io_dword    = {io_end_hi, io_start_hi};
    wire [31:0]  int_dword   = {16'h0000, INT_PIN_VALUE, int_scratch};
    wire [31:0]  next_pf_st  = merge_be(pf_start_hi, cfg_in.wdata, cfg_in.be);
    wire [31:0]  next_pf_end = merge_be(pf_end_hi, cfg_in.wdata, cfg_in.be);
    wire [31:0]  next_io     = merge_be(io_dword, cfg_in.wdata, cfg_in.be);
    wire [31:0]  next_int    = merge_be(int_dword, cfg_in.wdata, cfg_in.be);
    // Read-only bytes come from constants, so writes there simply fall away
    wire [31:0]  rd_mux      = hit_pf_st  ? pf_start_hi :
                               hit_pf_end ? pf_end_hi :
                               hit_io     ? io_dword :
                               hit_cap    ? {24'h000000, CAP_PTR_VALUE} :
                               hit_int    ? int_dword :
                                            32'h0000_0000;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pf_start_hi <= RST_PF_HI;
            pf_end_hi   <= RST_PF_HI;
            io_start_hi <= RST_IO_HI;
            io_end_hi   <= RST_IO_HI;
            int_scratch <= RST_INT_SCRATCH;
        end else if (wr_en) begin
            if (hit_pf_st)  pf_start_hi <= next_pf_st;
            if (hit_pf_end) pf_end_hi   <= next_pf_end;
            if (hit_io)     io_start_hi <= next_io[15:0];
            if (hit_io)     io_end_hi   <= next_io[31:16];
            if (hit_int)    int_scratch <= next_int[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cfg_ack   <= 1'b0;
            cfg_rdata <= 32'h0000_0000;
        end else begin
            cfg_ack   <= cfg_in.req;
            cfg_rdata <= (cfg_in.req && !cfg_in.we) ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Window assembly and forwarding decode
    // ------------------------------------------------------------
    // I/O space is 32 bits wide, so only the low 12 extension bits reach the compare
    wire [63:0] pf_start  = {pf_start_hi, pf_start_low, LOW_FILL_ZERO};
    wire [63:0] pf_end    = {pf_end_hi, pf_end_low, LOW_FILL_ONES};
    wire [31:0] io_start  = {io_start_hi[11:0], LOW_FILL_ZERO};
    wire [31:0] io_end    = {io_end_hi[11:0], LOW_FILL_ONES};
    wire        in_pf     = (fwd_in.addr >= pf_start) && (fwd_in.addr <= pf_end);
    wire        in_io     = (fwd_in.addr[63:32] == 32'h0000_0000)
                            && (fwd_in.addr[31:0] >= io_start)
                            && (fwd_in.addr[31:0] <= io_end);
    wire        next_hit  = fwd_in.valid && (fwd_in.is_io ? in_io : in_pf);

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fwd_done     <= 1'b0;
            fwd_hit      <= 1'b0;
            intx_primary <= '0;
        end else begin
            fwd_done     <= fwd_in.valid;
            fwd_hit      <= next_hit;
            intx_primary <= intx_secondary;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_n);

    sequence s_write(logic [5:0] idx);
        cfg_in.req && cfg_in.we && cfg_in.index == idx;
    endsequence

    sequence s_read(logic [5:0] idx);
        cfg_in.req && !cfg_in.we && cfg_in.index == idx;
    endsequence

    a_pf_start_write: assert property (
        s_write(cfg_index(OFS_PF_START_HI)) ##0 (cfg_in.be == 4'hf)
        |=> pf_start_hi == $past(cfg_in.wdata))
        else $error("prefetch start upper word not written");

    a_pf_end_readback: assert property (
        s_write(cfg_index(OFS_PF_END_HI)) ##0 (cfg_in.be == 4'hf)
        ##1 s_read(cfg_index(OFS_PF_END_HI))
        |=> cfg_ack && cfg_rdata == $past(cfg_in.wdata, 2))
        else $error("prefetch end upper word read back wrong");

    a_io_start_lanes: assert property (
        s_write(cfg_index(OFS_IO_START_HI)) ##0 (cfg_in.be == 4'h3)
        |=> io_start_hi == $past(cfg_in.wdata[15:0]) && $stable(io_end_hi))
        else $error("io start extension lane write wrong");

    a_io_end_lanes: assert property (
        s_write(cfg_index(OFS_IO_END_HI)) ##0 (cfg_in.be == 4'hc)
        |=> io_end_hi == $past(cfg_in.wdata[31:16]) && $stable(io_start_hi))
        else $error("io end extension lane write wrong");

    a_cap_ptr_const: assert property (
        s_read(cfg_index(OFS_CAP_PTR)) |=> cfg_ack && cfg_rdata == 32'h0000_0050)
        else $error("capability pointer did not read 50h");

    a_scratch_keeps: assert property (
        s_write(cfg_index(OFS_INT_SCRATCH)) ##0 !cfg_in.be[0] |=> $stable(int_scratch))
        else $error("scratch changed without its byte lane");

    a_int_pin_zero: assert property (
        s_write(cfg_index(OFS_INT_PIN)) ##1 s_read(cfg_index(OFS_INT_PIN))
        |=> cfg_rdata[15:8] == 8'h00)
        else $error("interrupt pin register not 00h");

    // The first edge after release still shows the reset copy, so it is skipped
    a_intx_passes: assert property (
        $past(rst_sync_n) |-> intx_primary == $past(intx_secondary))
        else $error("secondary interrupt not passed upstream");

    a_pf_start_edge: assert property (
        fwd_in.valid && !fwd_in.is_io && fwd_in.addr == pf_start - 64'h1 && pf_start != 0
        |=> !fwd_hit)
        else $error("address below prefetch start forwarded");

    a_pf_end_edge: assert property (
        fwd_in.valid && !fwd_in.is_io && fwd_in.addr == pf_end && pf_start <= pf_end
        |=> fwd_hit && fwd_done)
        else $error("prefetch end address not forwarded");

    a_io_window_hit: assert property (
        fwd_in.valid && fwd_in.is_io && fwd_in.addr == {32'h0, io_start} && io_start <= io_end
        |=> fwd_hit)
        else $error("io start address not forwarded");

endmodule

// >>> dv/cfg_host_model.sv
`timescale 1ns/1ps
module cfg_host_model
    import bridge_window_pkg::*;
(
    // Clock
    input  wire logic        sys_clk,
    // Configuration side
    output cfg_req_t         cfg_req,
    input  wire logic        cfg_ack,
    input  wire logic [31:0] cfg_rdata
);
    // Strobe stands one edge only; ack is read once that edge's updates land
    task automatic access(input logic we, input logic [5:0] idx, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] rd, output logic ack);
        @(posedge sys_clk);
        cfg_req <= '{req: 1'b1, we: we, index: idx, be: be, wdata: wd};
        @(posedge sys_clk);
        cfg_req <= '0;
        #1;
        ack = cfg_ack;
        rd  = cfg_rdata;
    endtask
    // Write then read of one index on consecutive edges, strobe held up between them
    task automatic write_read(input logic [5:0] idx, input logic [3:0] be,
                              input logic [31:0] wd, output logic wack,
                              output logic [31:0] rd, output logic ack);
        @(posedge sys_clk);
        cfg_req <= '{req: 1'b1, we: 1'b1, index: idx, be: be, wdata: wd};
        @(posedge sys_clk);
        cfg_req <= '{req: 1'b1, we: 1'b0, index: idx, be: 4'hf, wdata: 32'h0000_0000};
        #1;
        wack = cfg_ack;
        @(posedge sys_clk);
        cfg_req <= '0;
        #1;
        ack = cfg_ack;
        rd  = cfg_rdata;
    endtask
    initial cfg_req = '0;
endmodule

// >>> dv/bridge_window_upper_cfg_regs_tb.sv
`timescale 1ns/1ps
module bridge_window_upper_cfg_regs_tb import bridge_window_pkg::*;;
    logic        sys_clk, rst_n, cfg_ack, fwd_done, fwd_hit;
    cfg_req_t    cfg_in;
    fwd_req_t    fwd_in;
    logic [31:0] cfg_rdata;
    logic [11:0] pf_start_low, pf_end_low;
    logic [3:0]  intx_secondary, intx_primary;
    int          failures, samples_checked;

    bridge_window_upper_cfg_regs u_bridge_window_upper_cfg_regs (
        .sys_clk(sys_clk), .rst_n(rst_n), .cfg_in(cfg_in), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata), .pf_start_low(pf_start_low), .pf_end_low(pf_end_low),
        .fwd_in(fwd_in), .fwd_done(fwd_done), .fwd_hit(fwd_hit),
        .intx_secondary(intx_secondary), .intx_primary(intx_primary));
    cfg_host_model u_cfg_host_model (
        .sys_clk(sys_clk), .cfg_req(cfg_in), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));

    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Compare, access and closing tasks
    // ------------------------------------------------------------
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic reg_read(input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic        ack;
        u_cfg_host_model.access(1'b0, idx, 4'hf, 32'h0, rd, ack);
        check_bit(ack, 1'b1);
        check_word(rd, exp);
    endtask
    task automatic reg_write(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] wd);
        logic [31:0] rd;
        logic        ack;
        u_cfg_host_model.access(1'b1, idx, be, wd, rd, ack);
        check_bit(ack, 1'b1);
        check_word(rd, 32'h0);
    endtask
    task automatic reg_write_read(input logic [5:0] idx, input logic [3:0] be,
                                  input logic [31:0] wd, input logic [31:0] exp);
        logic [31:0] rd;
        logic        ack;
        logic        wack;
        u_cfg_host_model.write_read(idx, be, wd, wack, rd, ack);
        check_bit(wack, 1'b1);
        check_bit(ack, 1'b1);
        check_word(rd, exp);
    endtask
    task automatic fwd(input logic io, input logic [63:0] addr, input logic exp);
        @(posedge sys_clk);
        fwd_in <= '{valid: 1'b1, is_io: io, addr: addr};
        @(posedge sys_clk);
        fwd_in <= '0;
        #1;
        check_bit(fwd_done, 1'b1);
        check_bit(fwd_hit, exp);
    endtask
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Whole run is about 128 cycles; far beyond that means a hang
    initial begin
        #2000000;
        failures++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        fwd_in = '0;
        pf_start_low = 12'h0;
        pf_end_low = 12'h0;
        intx_secondary = 4'h0;
        failures = 0;
        samples_checked = 0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reg_read(6'h0a, 32'h0);
        reg_read(6'h0b, 32'h0);
        reg_read(6'h0c, 32'h0);
        reg_read(6'h0d, 32'h0000_0050);
        reg_read(6'h0f, 32'h0000_00ff);
        reg_read(6'h3f, 32'h0);
        $display("reset values test done");
        reg_write(6'h0a, 4'hf, 32'h8765_4321);
        reg_write(6'h0a, 4'h2, 32'hffff_aaff);
        reg_read(6'h0a, 32'h8765_aa21);
        reg_write(6'h0b, 4'hf, 32'h8765_aa21);
        reg_read(6'h0b, 32'h8765_aa21);
        reg_write(6'h0c, 4'hf, 32'h00ab_0012);
        reg_read(6'h0c, 32'h00ab_0012);
        reg_write(6'h0d, 4'hf, 32'hffff_ffff);
        reg_read(6'h0d, 32'h0000_0050);
        reg_write(6'h0f, 4'hf, 32'hffff_ff3c);
        reg_read(6'h0f, 32'h0000_003c);
        $display("register write test done");
        @(posedge sys_clk);
        pf_start_low <= 12'h010;
        pf_end_low <= 12'h100;
        fwd(1'b0, 64'h8765_aa21_00ff_ffff, 1'b0);
        fwd(1'b0, 64'h8765_aa21_0100_0000, 1'b1);
        fwd(1'b0, 64'h8765_aa21_100f_ffff, 1'b1);
        fwd(1'b0, 64'h8765_aa21_1010_0000, 1'b0);
        fwd(1'b0, 64'h0000_0000_0120_0000, 1'b0);
        fwd(1'b1, 64'h0000_0000_011f_ffff, 1'b0);
        fwd(1'b1, 64'h0000_0000_0120_0000, 1'b1);
        fwd(1'b1, 64'h0000_0000_0abf_ffff, 1'b1);
        fwd(1'b1, 64'h0000_0000_0ac0_0000, 1'b0);
        $display("forward decode test done");
        reg_write_read(6'h0b, 4'hf, 32'h0000_0001, 32'h0000_0001);
        reg_write_read(6'h0f, 4'h2, 32'h0000_5a00, 32'h0000_003c);
        reg_write(6'h0c, 4'h3, 32'hffff_f034);
        reg_read(6'h0c, 32'h00ab_f034);
        reg_write(6'h0c, 4'hc, 32'h0056_ffff);
        reg_read(6'h0c, 32'h0056_f034);
        fwd(1'b1, 64'h0000_0000_0340_0000, 1'b1);
        fwd(1'b1, 64'h0000_0000_056f_ffff, 1'b1);
        fwd(1'b1, 64'h0000_0001_0340_0000, 1'b0);
        $display("byte lane and back-to-back test done");
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            intx_secondary <= i[3:0];
            @(posedge sys_clk);
            #1;
            check_word({28'h0, intx_primary}, {28'h0, i[3:0]});
        end
        $display("interrupt pass-through test done");
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reg_read(6'h0a, 32'h0);
        reg_read(6'h0b, 32'h0);
        reg_read(6'h0c, 32'h0);
        reg_read(6'h0f, 32'h0000_00ff);
        check_word({28'h0, intx_primary}, 32'h0000_000f);
        $display("mid-run reset test done");
        end_sim();
    end
endmodule
